// File: logic/dfo_pkg.sv
package dfo_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TX_FRAME_CONTROL = 8'hA8;
    localparam logic [7:0] IDX_TX_SYNC_FIRST    = 8'hA9;
    localparam logic [7:0] IDX_TX_SYNC_LAST     = 8'hAA;
    localparam logic [7:0] IDX_TX_OVERHEAD_ONE  = 8'hB1;
    localparam logic [7:0] IDX_TX_OVERHEAD_TWO  = 8'hB2;
    localparam logic [7:0] IDX_TX_OVERHEAD_THR  = 8'hB3;
    localparam logic [7:0] IDX_TX_OVERHEAD_FOUR = 8'hB4;
    localparam logic [7:0] IDX_RX_CONTROL       = 8'hC0;
    localparam logic [7:0] IDX_RX_TEST_CONTROL  = 8'hC1;
    localparam logic [7:0] IDX_RX_STATUS        = 8'hC8;
    localparam logic [7:0] IDX_CRC_COUNT        = 8'hC9;

    localparam logic [7:0] RESET_VALUE          = 8'h00;

    // Writable bit masks; reserved bits are kept at zero
    localparam logic [7:0] MASK_SYNC_LAST       = 8'h03;
    localparam logic [7:0] MASK_RX_CONTROL      = 8'h7F;
    localparam logic [7:0] MASK_RX_TEST         = 8'h02;

    // tx_frame_control fields
    localparam int TFC_PAYLOAD_FILL  = 0;
    localparam int TFC_FILL_LEVEL    = 1;
    localparam int TFC_SYNC_INHIBIT  = 2;
    localparam int TFC_SCRAM_EN      = 3;
    localparam int TFC_TX_POLY_DIR   = 4;
    localparam int TFC_DESCRAM_EN    = 5;
    localparam int TFC_RX_POLY_DIR   = 6;
    localparam int TFC_OVERHEAD_NML  = 7;

    // rx_control fields
    localparam int RXC_FRAME_CLR     = 0;
    localparam int RXC_RESYNC        = 1;
    localparam int RXC_STUFF_QUAL    = 2;
    localparam int RXC_DET_LEVEL     = 3;
    localparam int RXC_DET_CLEAR     = 4;
    localparam int RXC_CRC_CLEAR     = 5;
    localparam int RXC_AUTO_LOSS     = 6;

    // rx_test_control fields
    localparam int RXT_FIFO_BLOCK    = 1;
    localparam int RXT_DS1_HOLD      = 2;

    // rx_status fields
    localparam int RXS_FRAME_EVENT   = 0;
    localparam int RXS_SYNC_DETECT   = 2;
    localparam int RXS_FRAME_SYNC    = 3;
    localparam int RXS_PATTERN       = 6;

    localparam logic [3:0] DS1_HOLD_CYCLES = 4'h8;
    localparam logic [2:0] LOSS_FRAMES     = 3'h5;
    localparam logic [6:0] PATTERN_LEN     = 7'h40;
    localparam logic [4:0] SYNC_LEN        = 5'h0A;
    localparam logic [4:0] MAP_LEN         = 5'h1C;

    // Self-synchronising scrambler x^-23 + x^-k + 1
    localparam int SCRAM_LEN    = 23;
    localparam int TAP_TO_CENT  = 5;
    localparam int TAP_TO_REM   = 18;

    typedef enum logic [1:0] {FLD_PAYLOAD, FLD_OVERHEAD, FLD_SYNC, FLD_STUFF} dfo_field_t;
    typedef enum logic [1:0] {SY_HUNT, SY_CONFIRM, SY_LOCKED} dfo_sync_t;

endpackage

// File: logic/dfo_frame_overhead_control.sv
`timescale 1ns/1ps
module dfo_frame_overhead_control (
    input  wire logic               mclk,
    input  wire logic               nrst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic               tx_in_valid,
    input  wire dfo_pkg::dfo_field_t tx_field,
    input  wire logic [4:0]         tx_index,
    input  wire logic               tx_in_bit,
    output logic                    tx_out_valid,
    output logic                    tx_out_bit,
    input  wire logic               rx_in_valid,
    input  wire logic               rx_in_bit,
    output logic                    rx_out_valid,
    output logic                    rx_out_bit,
    input  wire logic               rx_frame_end,
    input  wire logic               rx_fsw_ok,
    input  wire logic               rx_stuff_ok,
    input  wire logic               rx_crc_error,
    output logic                    rx_frame_sync,
    output logic                    rx_realign,
    output logic                    rx_frame_irq,
    output logic                    rx_fifo_write_block,
    output logic                    ds1_count_hold
);

    localparam int SCRAM_LEN_W = dfo_pkg::SCRAM_LEN;

    logic [7:0]              tx_frame_control;
    logic [7:0]              tx_sync_word_first;
    logic [7:0]              tx_sync_word_last;
    logic [7:0]              tx_overhead_one;
    logic [7:0]              tx_overhead_two;
    logic [7:0]              tx_overhead_three;
    logic [7:0]              tx_overhead_four;
    logic [7:0]              rx_control;
    logic [7:0]              rx_test_control;
    logic [7:0]              crc_error_counter;
    logic                    wr_pend;
    logic [7:0]              wr_idx;
    logic [SCRAM_LEN_W-1:0]  tx_scram;
    logic [SCRAM_LEN_W-1:0]  rx_scram;
    logic [6:0]              run_len;
    logic                    pattern_flag;
    logic                    frame_event;
    logic                    sync_detect;
    logic [2:0]              bad_frames;
    logic [3:0]              hold_cnt;
    dfo_pkg::dfo_sync_t      sync_state;
    dfo_pkg::dfo_sync_t      next_sync_state;

    // AHB-Lite slave: zero wait states, always OKAY
    wire        addr_take  = hsel && htrans[1] && hready;
    wire [7:0]  addr_idx   = haddr[9:2];
    wire [7:0]  wdat       = hwdata[7:0];
    wire        wr_frame   = wr_pend && (wr_idx == dfo_pkg::IDX_TX_FRAME_CONTROL);
    wire        wr_first   = wr_pend && (wr_idx == dfo_pkg::IDX_TX_SYNC_FIRST);
    wire        wr_last    = wr_pend && (wr_idx == dfo_pkg::IDX_TX_SYNC_LAST);
    wire        wr_oh1     = wr_pend && (wr_idx == dfo_pkg::IDX_TX_OVERHEAD_ONE);
    wire        wr_oh2     = wr_pend && (wr_idx == dfo_pkg::IDX_TX_OVERHEAD_TWO);
    wire        wr_oh3     = wr_pend && (wr_idx == dfo_pkg::IDX_TX_OVERHEAD_THR);
    wire        wr_oh4     = wr_pend && (wr_idx == dfo_pkg::IDX_TX_OVERHEAD_FOUR);
    wire        wr_rxc     = wr_pend && (wr_idx == dfo_pkg::IDX_RX_CONTROL);
    wire        wr_test    = wr_pend && (wr_idx == dfo_pkg::IDX_RX_TEST_CONTROL);
    wire        crc_clear  = wr_rxc && wdat[dfo_pkg::RXC_CRC_CLEAR];
    wire        det_clear  = wr_rxc && wdat[dfo_pkg::RXC_DET_CLEAR];
    wire        hold_start = wr_test && wdat[dfo_pkg::RXT_DS1_HOLD];

    wire [7:0]  rx_status  = {1'b0, pattern_flag, 2'b00, (sync_state == dfo_pkg::SY_LOCKED),
                              sync_detect, 1'b0, frame_event};

    logic [7:0] rd_mux;
    always_comb begin
        unique case (addr_idx)
            dfo_pkg::IDX_TX_FRAME_CONTROL: rd_mux = tx_frame_control;
            dfo_pkg::IDX_TX_SYNC_FIRST:    rd_mux = tx_sync_word_first;
            dfo_pkg::IDX_TX_SYNC_LAST:     rd_mux = tx_sync_word_last;
            dfo_pkg::IDX_TX_OVERHEAD_ONE:  rd_mux = tx_overhead_one;
            dfo_pkg::IDX_TX_OVERHEAD_TWO:  rd_mux = tx_overhead_two;
            dfo_pkg::IDX_TX_OVERHEAD_THR:  rd_mux = tx_overhead_three;
            dfo_pkg::IDX_TX_OVERHEAD_FOUR: rd_mux = tx_overhead_four;
            dfo_pkg::IDX_RX_CONTROL:       rd_mux = rx_control;
            dfo_pkg::IDX_RX_TEST_CONTROL:  rd_mux = rx_test_control;
            dfo_pkg::IDX_RX_STATUS:        rd_mux = rx_status;
            dfo_pkg::IDX_CRC_COUNT:        rd_mux = crc_error_counter;
            default:                       rd_mux = 8'h00;
        endcase
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_pend <= 1'b0;
            wr_idx  <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_take && hwrite;
            wr_idx  <= addr_idx;
            hrdata  <= (addr_take && !hwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_frame_control   <= dfo_pkg::RESET_VALUE;
            tx_sync_word_first <= dfo_pkg::RESET_VALUE;
            tx_sync_word_last  <= dfo_pkg::RESET_VALUE;
            tx_overhead_one    <= dfo_pkg::RESET_VALUE;
            tx_overhead_two    <= dfo_pkg::RESET_VALUE;
            tx_overhead_three  <= dfo_pkg::RESET_VALUE;
            tx_overhead_four   <= dfo_pkg::RESET_VALUE;
            rx_control         <= dfo_pkg::RESET_VALUE;
            rx_test_control    <= dfo_pkg::RESET_VALUE;
        end else begin
            if (wr_frame) tx_frame_control <= wdat;
            if (wr_first) tx_sync_word_first <= wdat;
            if (wr_last) tx_sync_word_last <= wdat & dfo_pkg::MASK_SYNC_LAST;
            if (wr_oh1) tx_overhead_one <= wdat;
            if (wr_oh2) tx_overhead_two <= wdat;
            if (wr_oh3) tx_overhead_three <= wdat;
            if (wr_oh4) tx_overhead_four <= wdat;
            if (wr_rxc) rx_control <= wdat & dfo_pkg::MASK_RX_CONTROL;
            if (wr_test) rx_test_control <= wdat & dfo_pkg::MASK_RX_TEST;
        end
    end

    // Transmit insertion
    wire fill_level   = tx_frame_control[dfo_pkg::TFC_FILL_LEVEL];
    wire payload_fill = tx_frame_control[dfo_pkg::TFC_PAYLOAD_FILL];
    wire sync_fill    = payload_fill && tx_frame_control[dfo_pkg::TFC_SYNC_INHIBIT];
    wire oh_fill      = payload_fill && (tx_frame_control[dfo_pkg::TFC_SYNC_INHIBIT]
                        || !tx_frame_control[dfo_pkg::TFC_OVERHEAD_NML]);

    wire [9:0]  sync_word = {tx_sync_word_first, tx_sync_word_last[1:0]};
    wire        sync_bit  = (tx_index < dfo_pkg::SYNC_LEN) ? sync_word[4'(4'd9 - tx_index[3:0])] : 1'b0;
    wire        stuff_bit = tx_overhead_four[2'(2'd3 - tx_index[1:0])];

    // EOC 24..1 then loss-of-signal, segment defect, segment anomaly, indicator
    wire [27:0] oh_map = {tx_overhead_three[7], tx_overhead_four[4], tx_overhead_four[6],
                          tx_overhead_three[5], tx_overhead_three[4:0], tx_overhead_two[7:6],
                          tx_overhead_four[7], tx_overhead_two[5:0], tx_overhead_one[7],
                          tx_overhead_four[5], tx_overhead_one[6:0], tx_overhead_three[6]};
    wire        oh_bit    = (tx_index < dfo_pkg::MAP_LEN) ? oh_map[tx_index] : tx_in_bit;

    logic src_bit;
    always_comb begin
        unique case (tx_field)
            dfo_pkg::FLD_PAYLOAD:  src_bit = payload_fill ? fill_level : tx_in_bit;
            dfo_pkg::FLD_OVERHEAD: src_bit = oh_fill ? fill_level : oh_bit;
            dfo_pkg::FLD_SYNC:     src_bit = sync_fill ? fill_level : sync_bit;
            dfo_pkg::FLD_STUFF:    src_bit = sync_fill ? fill_level : stuff_bit;
        endcase
    end

    // Sync word passes unscrambled; the scrambler feeds back its own output
    wire tx_tap     = tx_frame_control[dfo_pkg::TFC_TX_POLY_DIR] ? tx_scram[dfo_pkg::TAP_TO_CENT - 1]
                                                                : tx_scram[dfo_pkg::TAP_TO_REM - 1];
    wire tx_scr_on  = tx_frame_control[dfo_pkg::TFC_SCRAM_EN] && (tx_field != dfo_pkg::FLD_SYNC);
    wire next_tx_bit = tx_scr_on ? (src_bit ^ tx_scram[SCRAM_LEN_W-1] ^ tx_tap) : src_bit;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_out_valid <= 1'b0;
            tx_out_bit   <= 1'b0;
            tx_scram     <= '0;
        end else begin
            tx_out_valid <= tx_in_valid;
            if (tx_in_valid) tx_out_bit <= next_tx_bit;
            if (tx_in_valid && tx_field != dfo_pkg::FLD_SYNC) tx_scram <= {tx_scram[SCRAM_LEN_W-2:0], next_tx_bit};
        end
    end

    // Receive descrambler, shifts in the line bits
    wire rx_tap      = tx_frame_control[dfo_pkg::TFC_RX_POLY_DIR] ? rx_scram[dfo_pkg::TAP_TO_CENT - 1]
                                                                 : rx_scram[dfo_pkg::TAP_TO_REM - 1];
    wire next_rx_bit = tx_frame_control[dfo_pkg::TFC_DESCRAM_EN] ?
                       (rx_in_bit ^ rx_scram[SCRAM_LEN_W-1] ^ rx_tap) : rx_in_bit;

    // Pattern run length saturates at the pattern length
    wire       det_match    = next_rx_bit == rx_control[dfo_pkg::RXC_DET_LEVEL];
    wire [6:0] next_run_len = !det_match ? 7'h00 :
                              (run_len == dfo_pkg::PATTERN_LEN) ? run_len : 7'(run_len + 7'h01);
    wire       det_set      = rx_in_valid && (next_run_len == dfo_pkg::PATTERN_LEN);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_out_valid <= 1'b0;
            rx_out_bit   <= 1'b0;
            rx_scram     <= '0;
            run_len      <= 7'h00;
            pattern_flag <= 1'b0;
        end else begin
            rx_out_valid <= rx_in_valid;
            if (rx_in_valid) begin
                rx_out_bit <= next_rx_bit;
                rx_scram   <= {rx_scram[SCRAM_LEN_W-2:0], rx_in_bit};
                run_len    <= next_run_len;
            end
            if (det_set) pattern_flag <= 1'b1;
            else if (det_clear) pattern_flag <= 1'b0;
        end
    end

    // Frame sync acquisition and loss
    wire frame_good = rx_fsw_ok && (!rx_control[dfo_pkg::RXC_STUFF_QUAL] || rx_stuff_ok);
    wire auto_loss  = rx_control[dfo_pkg::RXC_AUTO_LOSS];
    wire resync     = rx_control[dfo_pkg::RXC_RESYNC];

    always_comb begin
        next_sync_state = sync_state;
        if (resync) begin
            next_sync_state = dfo_pkg::SY_HUNT;
        end else if (rx_frame_end) begin
            unique case (sync_state)
                dfo_pkg::SY_HUNT:    next_sync_state = frame_good ? dfo_pkg::SY_CONFIRM : dfo_pkg::SY_HUNT;
                dfo_pkg::SY_CONFIRM: next_sync_state = frame_good ? dfo_pkg::SY_LOCKED : dfo_pkg::SY_HUNT;
                dfo_pkg::SY_LOCKED: begin
                    if (!rx_fsw_ok && auto_loss && bad_frames == 3'(dfo_pkg::LOSS_FRAMES - 3'h1))
                        next_sync_state = dfo_pkg::SY_HUNT;
                end
                default:             next_sync_state = dfo_pkg::SY_HUNT;
            endcase
        end
    end

    wire frame_clr = rx_control[dfo_pkg::RXC_FRAME_CLR];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync_state  <= dfo_pkg::SY_HUNT;
            bad_frames  <= 3'h0;
            frame_event <= 1'b0;
            sync_detect <= 1'b0;
        end else begin
            sync_state <= next_sync_state;
            if (next_sync_state != dfo_pkg::SY_LOCKED) bad_frames <= 3'h0;
            else if (rx_frame_end) bad_frames <= rx_fsw_ok ? 3'h0 : 3'(bad_frames + 3'h1);
            if (frame_clr) begin
                frame_event <= 1'b0;
                sync_detect <= 1'b0;
            end else if (rx_frame_end) begin
                frame_event <= 1'b1;
                sync_detect <= rx_fsw_ok;
            end
        end
    end

    assign rx_frame_sync       = sync_state == dfo_pkg::SY_LOCKED;
    assign rx_realign          = resync;
    assign rx_frame_irq        = frame_event && !frame_clr;
    assign rx_fifo_write_block = rx_test_control[dfo_pkg::RXT_FIFO_BLOCK];
    assign ds1_count_hold      = hold_cnt != 4'h0;

    // CRC error counter: an error in the clearing cycle still counts
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            crc_error_counter <= 8'h00;
            hold_cnt          <= 4'h0;
        end else begin
            if (crc_clear) crc_error_counter <= rx_crc_error ? 8'h01 : 8'h00;
            else if (rx_crc_error && crc_error_counter != 8'hFF)
                crc_error_counter <= 8'(crc_error_counter + 8'h01);
            if (hold_start) hold_cnt <= dfo_pkg::DS1_HOLD_CYCLES;
            else if (hold_cnt != 4'h0) hold_cnt <= 4'(hold_cnt - 4'h1);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_hold_write;
        hold_start;
    endsequence
    sequence s_hold_run;
        ds1_count_hold [*8];
    endsequence
    sequence s_hold_end;
        ds1_count_hold ##1 !ds1_count_hold;
    endsequence

    chk_ds1_hold_len: assert property (s_hold_write ##1 !hold_start [*8] |-> s_hold_end)
        else $error("DS1 hold not exactly eight cycles");
    chk_ds1_hold_start: assert property (s_hold_write |=> s_hold_run)
        else $error("DS1 hold dropped early");
    chk_sync_word: assert property ((tx_in_valid && tx_field == dfo_pkg::FLD_SYNC && !sync_fill
        && tx_index < dfo_pkg::SYNC_LEN)
        |=> tx_out_bit == $past(sync_word[4'(4'd9 - tx_index[3:0])]))
        else $error("Sync word bit order wrong");
    chk_payload_fill: assert property ((tx_in_valid && tx_field == dfo_pkg::FLD_PAYLOAD && payload_fill
        && !tx_frame_control[dfo_pkg::TFC_SCRAM_EN]) |=> tx_out_bit == $past(fill_level))
        else $error("Payload fill level wrong");
    chk_overhead_map: assert property ((tx_in_valid && tx_field == dfo_pkg::FLD_OVERHEAD && !oh_fill
        && tx_index < dfo_pkg::MAP_LEN && !tx_frame_control[dfo_pkg::TFC_SCRAM_EN])
        |=> tx_out_bit == $past(oh_map[tx_index]))
        else $error("Overhead bit not as written");
    chk_overhead_fill: assert property ((tx_in_valid && tx_field == dfo_pkg::FLD_OVERHEAD && payload_fill
        && !tx_frame_control[dfo_pkg::TFC_OVERHEAD_NML] && !tx_frame_control[dfo_pkg::TFC_SCRAM_EN])
        |=> tx_out_bit == $past(fill_level))
        else $error("Overhead not filled");
    chk_loss_five: assert property ((sync_state == dfo_pkg::SY_LOCKED && auto_loss && !resync
        && rx_frame_end && !rx_fsw_ok && bad_frames == 3'h4) |=> !rx_frame_sync)
        else $error("Sync not lost after five bad frames");
    chk_stuff_qual: assert property ((sync_state != dfo_pkg::SY_LOCKED && rx_frame_end && rx_fsw_ok
        && !rx_stuff_ok && rx_control[dfo_pkg::RXC_STUFF_QUAL]) |=> !rx_frame_sync)
        else $error("Locked despite bad stuff bits");
    chk_crc_clear: assert property ((crc_clear && !rx_crc_error) |=> crc_error_counter == 8'h00)
        else $error("CRC counter not cleared");
    chk_pattern_set: assert property ((rx_in_valid && det_match && run_len == 7'h3F) |=> pattern_flag)
        else $error("Pattern flag missed");
    chk_pattern_clear: assert property ((det_clear && !det_set) |=> !pattern_flag)
        else $error("Pattern flag not cleared");
    chk_frame_mask: assert property (frame_clr |=> !rx_frame_irq && !frame_event)
        else $error("Frame interrupt not masked");
    chk_realign: assert property (resync |=> sync_state == dfo_pkg::SY_HUNT)
        else $error("Realign did not drop sync");
    chk_descram_off: assert property ((rx_in_valid && !tx_frame_control[dfo_pkg::TFC_DESCRAM_EN])
        |=> rx_out_bit == $past(rx_in_bit))
        else $error("Descrambler altered data while off");
    chk_scram_off: assert property ((tx_in_valid && !tx_frame_control[dfo_pkg::TFC_SCRAM_EN])
        |=> tx_out_bit == $past(src_bit))
        else $error("Scrambler altered data while off");
    chk_manual_loss: assert property ((rx_frame_sync && !auto_loss && !resync) |=> rx_frame_sync)
        else $error("Sync dropped with automatic loss off");
    chk_crc_count: assert property ((rx_crc_error && !crc_clear && crc_error_counter != 8'hFF)
        |=> crc_error_counter == 8'($past(crc_error_counter) + 8'h01))
        else $error("CRC error not counted");
    chk_frame_event: assert property ((rx_frame_end && !frame_clr) |=> frame_event)
        else $error("Frame event not recorded");

endmodule // dfo_frame_overhead_control

// File: bench/dfo_line_model.sv
`timescale 1ns/1ps
module dfo_line_model (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic good,
    input  wire logic level,
    output logic      rx_in_valid,
    output logic      rx_in_bit,
    output logic      rx_frame_end,
    output logic      rx_fsw_ok,
    output logic      rx_stuff_ok,
    output logic      rx_crc_error
);
    logic [3:0] slot;
    // Sixteen-bit frames; qualifiers toggle between frame ends; stuff bits follow level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot         <= 4'h0;
            rx_in_valid  <= 1'b0;
            rx_in_bit    <= 1'b0;
            rx_frame_end <= 1'b0;
            rx_fsw_ok    <= 1'b0;
            rx_stuff_ok  <= 1'b0;
            rx_crc_error <= 1'b0;
        end else begin
            slot         <= slot + 4'h1;
            rx_in_valid  <= 1'b1;
            rx_in_bit    <= level;
            rx_frame_end <= (slot == 4'hF);
            rx_fsw_ok    <= (slot == 4'hF) ? good : slot[0];
            rx_stuff_ok  <= (slot == 4'hF) ? level : ~slot[0];
            rx_crc_error <= (slot == 4'hF) & ~good;
        end
    end
endmodule // dfo_line_model

// File: bench/dsl_frame_overhead_control_tb.sv
`timescale 1ns/1ps
module dsl_frame_overhead_control_tb;
    logic mclk, nrst, hsel, hwrite, hreadyout, hresp, good, level, tx_in_valid, tx_in_bit, tx_out_bit;
    logic rx_in_valid, rx_in_bit, rx_frame_end, rx_fsw_ok, rx_stuff_ok, rx_crc_error, rx_frame_sync;
    logic rx_realign, rx_frame_irq, rx_fifo_write_block, ds1_count_hold, tx_out_valid, rx_out_valid, rx_out_bit;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  tx_index;
    logic [7:0]  c;
    dfo_pkg::dfo_field_t tx_field;
    int err_count, n_checks, cyc, k;
    logic [7:0] idx[10] = '{8'hA8, 8'hA9, 8'hAA, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hC0, 8'hC1, 8'hC5};
    logic [7:0] cfg[5] = '{8'h80, 8'h83, 8'h03, 8'h05, 8'h06};
    logic [9:0] sw = {8'hA5, 2'h2};
    dfo_frame_overhead_control uut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .tx_in_valid(tx_in_valid), .tx_field(tx_field), .tx_index(tx_index),
        .tx_in_bit(tx_in_bit), .tx_out_valid(tx_out_valid), .tx_out_bit(tx_out_bit), .rx_in_valid(rx_in_valid),
        .rx_in_bit(rx_in_bit), .rx_out_valid(rx_out_valid), .rx_out_bit(rx_out_bit), .rx_frame_end(rx_frame_end),
        .rx_fsw_ok(rx_fsw_ok), .rx_stuff_ok(rx_stuff_ok), .rx_crc_error(rx_crc_error),
        .rx_frame_sync(rx_frame_sync), .rx_realign(rx_realign), .rx_frame_irq(rx_frame_irq),
        .rx_fifo_write_block(rx_fifo_write_block), .ds1_count_hold(ds1_count_hold));
    dfo_line_model line (.mclk(mclk), .nrst(nrst), .good(good), .level(level), .rx_in_valid(rx_in_valid),
        .rx_in_bit(rx_in_bit), .rx_frame_end(rx_frame_end), .rx_fsw_ok(rx_fsw_ok),
        .rx_stuff_ok(rx_stuff_ok), .rx_crc_error(rx_crc_error));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            err_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, i, 2'h0};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic tx(input dfo_pkg::dfo_field_t f, input logic [4:0] i, input logic b, input logic e);
        @(posedge mclk);
        tx_in_valid <= 1'b1;
        tx_field <= f;
        tx_index <= i;
        tx_in_bit <= b;
        @(posedge mclk);
        tx_in_valid <= 1'b0;
        #1 chk("tx_out_bit", {31'h0, e}, {31'h0, tx_out_bit});
        chk("tx_out_valid", 32'h1, {31'h0, tx_out_valid});
    endtask
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge mclk);
            while (rx_frame_end !== 1'b1) @(posedge mclk);
        end
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        {nrst, hsel, hwrite, tx_in_valid, tx_in_bit, haddr, hwdata, htrans, hsize, tx_index} = '0;
        hsize = 3'h2;
        tx_field = dfo_pkg::FLD_PAYLOAD;
        good = 1;
        level = 1;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        foreach (idx[i]) begin
            bus(0, idx[i], 8'h00);
            chk("reset value", 32'h0, rd);
        end
        bus(1, 8'hA9, 8'hA5);
        bus(1, 8'hAA, 8'h02);
        bus(1, 8'hB1, 8'h01);
        bus(1, 8'hB4, 8'h08);
        bus(1, 8'hA8, 8'h80);
        for (k = 0; k < 10; k++) tx(dfo_pkg::FLD_SYNC, 5'(k), 1'b0, sw[9-k]);
        tx(dfo_pkg::FLD_OVERHEAD, 5'h01, 1'b0, 1'b1);
        tx(dfo_pkg::FLD_OVERHEAD, 5'h00, 1'b1, 1'b0);
        tx(dfo_pkg::FLD_STUFF, 5'h00, 1'b0, 1'b1);
        tx(dfo_pkg::FLD_STUFF, 5'h03, 1'b1, 1'b0);
        $display("transmit map test done");
        foreach (cfg[i]) begin
            c = cfg[i];
            bus(1, 8'hA8, c);
            tx(dfo_pkg::FLD_PAYLOAD, 5'h00, ~c[1], c[0] ? c[1] : ~c[1]);
            tx(dfo_pkg::FLD_OVERHEAD, 5'h1C, ~c[1], (c[0] & (c[2] | ~c[7])) ? c[1] : ~c[1]);
            tx(dfo_pkg::FLD_SYNC, 5'h00, 1'b0, (c[0] & c[2]) ? c[1] : 1'b1);
        end
        $display("fill test done");
        bus(1, 8'hC0, 8'h48);
        frames(5);
        chk("frame_irq", 32'h1, {31'h0, rx_frame_irq});
        bus(0, 8'hC8, 8'h00);
        chk("status", 32'h48, rd & 32'h48);
        good = 0;
        frames(4);
        chk("sync after 4", 32'h1, {31'h0, rx_frame_sync});
        frames(1);
        chk("sync after 5", 32'h0, {31'h0, rx_frame_sync});
        good = 1;
        bus(0, 8'hC9, 8'h00);
        chk("crc count", 32'h5, rd);
        bus(1, 8'hC0, 8'h68);
        bus(1, 8'hC0, 8'h48);
        bus(0, 8'hC9, 8'h00);
        chk("crc cleared", 32'h0, rd);
        level = 0;
        frames(1);
        bus(1, 8'hC0, 8'h58);
        bus(0, 8'hC8, 8'h00);
        chk("pattern clear", 32'h0, rd & 32'h40);
        bus(1, 8'hC0, 8'h40);
        frames(5);
        bus(0, 8'hC8, 8'h00);
        chk("zero pattern", 32'h40, rd & 32'h40);
        chk("rx_out_bit", 32'h0, {31'h0, rx_out_bit});
        chk("rx_out_valid", 32'h1, {31'h0, rx_out_valid});
        bus(1, 8'hC0, 8'h41);
        #1 chk("irq masked", 32'h0, {31'h0, rx_frame_irq});
        bus(0, 8'hC8, 8'h00);
        chk("event clear", 32'h0, rd & 32'h05);
        bus(1, 8'hC0, 8'h42);
        #1 chk("realign", 32'h1, {31'h0, rx_realign});
        bus(1, 8'hC0, 8'h40);
        bus(1, 8'hC0, 8'h46);
        bus(1, 8'hC0, 8'h44);
        frames(3);
        chk("stuff qual", 32'h0, {31'h0, rx_frame_sync});
        bus(1, 8'hC0, 8'h40);
        frames(3);
        chk("sync regained", 32'h1, {31'h0, rx_frame_sync});
        $display("receive control test done");
        bus(1, 8'hC1, 8'h02);
        #1 chk("fifo block", 32'h1, {31'h0, rx_fifo_write_block});
        bus(1, 8'hC1, 8'h04);
        #1 k = ds1_count_hold;
        chk("fifo unblock", 32'h0, {31'h0, rx_fifo_write_block});
        repeat (13) @(posedge mclk) #1 k += ds1_count_hold;
        chk("hold cycles", 32'h8, 32'(k));
        $display("receive test control done");
        summarize();
    end
endmodule // dsl_frame_overhead_control_tb
